// ==== src/aoc_capture.sv ====
`timescale 1ns/1ps
module aoc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wptr_q;
    logic [AW-1:0] rptr_q;
    logic [AW:0] cnt_q;
    logic ovalid_q;
    logic [WIDTH-1:0] odata_q;
    logic push;
    logic pop;

    assign in_ready = (cnt_q != (AW+1)'(DEPTH));
    assign push = in_valid & in_ready;
    assign pop = (cnt_q != '0) & (~ovalid_q | out_ready);

    always_ff @(posedge mclk) begin
        if (push) begin
            mem_q[wptr_q] <= in_data;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= wptr_q + 1'b1;
            end
            if (pop) begin
                rptr_q <= rptr_q + 1'b1;
            end
            cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ovalid_q <= 1'b0;
            odata_q <= '0;
        end else if (pop) begin
            ovalid_q <= 1'b1;
            odata_q <= mem_q[rptr_q];
        end else if (out_ready) begin
            ovalid_q <= 1'b0;
        end
    end

    assign out_valid = ovalid_q;
    assign out_data = odata_q;
    assign level = cnt_q;
endmodule // aoc_fifo

module aoc_capture
    import aoc_pkg::*;
#(
    parameter int DEPTH = FIFO_DEPTH,
    parameter int SLACK = FIFO_SLACK
) (
    input wire logic mclk,
    input wire logic arst_n,
    aoc_link_if.cap link,
    input wire logic run,
    output logic sample_valid,
    input wire logic sample_ready,
    output logic [CODE_W-1:0] sample_code,
    output logic [CODE_W-1:0] sample_twos,
    output logic out_of_range_flag,
    output logic over_range,
    output logic under_range,
    output logic in_range
);
    aoc_gen_t gen_q;
    logic sclk_q;
    logic stall;
    logic [CAP_W-1:0] cap_word;
    logic [CAP_W-1:0] out_word;
    logic [$clog2(DEPTH):0] level;

    // Stop the clock early so in-flight samples still fit
    assign stall = (32'(level) >= DEPTH - SLACK);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gen_q <= AOC_IDLE;
        end else begin
            case (gen_q)
                AOC_IDLE: if (run && !stall) gen_q <= AOC_RUN;
                AOC_RUN: if ((!run || stall) && !sclk_q) gen_q <= AOC_IDLE;
                default: gen_q <= AOC_IDLE;
            endcase
        end
    end

    // Divide-by-two from mclk, output straight from a flop
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= RST_SCLK;
        end else if (gen_q == AOC_RUN) begin
            sclk_q <= ~sclk_q;
        end else begin
            sclk_q <= 1'b0;
        end
    end
    assign link.sample_clk = sclk_q;

    always_comb begin
        cap_word = {
            ~link.out_of_range_flag,
            link.out_of_range_flag & ~link.code[CODE_W-1],
            link.out_of_range_flag & link.code[CODE_W-1],
            link.out_of_range_flag,
            {~link.code[CODE_W-1], link.code[CODE_W-2:0]},
            link.code
        };
    end

    aoc_fifo #(
        .WIDTH(CAP_W),
        .DEPTH(DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .arst_n(arst_n),
        .in_valid(link.word_valid),
        .in_ready(),
        .in_data(cap_word),
        .out_valid(sample_valid),
        .out_ready(sample_ready),
        .out_data(out_word),
        .level(level)
    );

    assign sample_code = out_word[CODE_W-1:0];
    assign sample_twos = out_word[2*CODE_W-1:CODE_W];
    assign out_of_range_flag = out_word[2*CODE_W];
    assign over_range = out_word[2*CODE_W+1];
    assign under_range = out_word[2*CODE_W+2];
    assign in_range = out_word[2*CODE_W+3];
endmodule // aoc_capture

// ==== src/aoc_pkg.sv ====
package aoc_pkg;
    localparam int CODE_W = 12;
    localparam int IN_W = 14;
    localparam logic [CODE_W-1:0] CODE_ZERO = 12'h000;
    localparam logic [CODE_W-1:0] CODE_MID = 12'h800;
    localparam logic [CODE_W-1:0] CODE_FULL = 12'hFFF;
    // Input in LSB units: -VREF is -2048, +VREF is +2048
    localparam logic signed [IN_W-1:0] IN_NEG_REF = -14'sd2048;
    localparam logic signed [IN_W-1:0] IN_POS_REF = 14'sd2048;
    localparam int MCLK_HZ = 50_000_000;
    localparam int SCLK_HZ = 25_000_000;
    localparam int SCLK_DIV = MCLK_HZ / SCLK_HZ;
    localparam int PIPE_STAGES = 3;
    localparam int FIFO_DEPTH = 16;
    localparam int FIFO_SLACK = PIPE_STAGES + 3;
    localparam logic RST_SCLK = 1'b0;
    // Capture word: in_range, under, over, flag, twos, code
    localparam int CAP_W = 4 + 2 * CODE_W;

    typedef enum logic [1:0] {
        AOC_IDLE = 2'b01,
        AOC_RUN = 2'b10
    } aoc_gen_t;
endpackage

// ==== src/aoc_link_if.sv ====
`timescale 1ns/1ps
interface aoc_link_if;
    import aoc_pkg::*;
    logic sample_clk;
    logic [CODE_W-1:0] code;
    logic out_of_range_flag;
    logic word_valid;

    modport dev (
        input sample_clk,
        output code,
        output out_of_range_flag,
        output word_valid
    );
    modport cap (
        output sample_clk,
        input code,
        input out_of_range_flag,
        input word_valid
    );
endinterface

// ==== src/aoc_converter.sv ====
`timescale 1ns/1ps
// Function
// - Straight binary code for every input range
// - Receiver inverts MSB for twos complement
// - Clamp codes and flag per table
// - Flag shares the code's pipeline
// - Flag low in range, high outside
// - Flag clears only after in-range conversion
// - Flag with MSB decodes under/over range
// - Timing uses both sample clock edges
// - Source divides double-rate clock by two
// - Derived sample clock retimed by converter
module aoc_converter
    import aoc_pkg::*;
#(
    parameter int STAGES = PIPE_STAGES
) (
    input wire logic mclk,
    input wire logic arst_n,
    aoc_link_if.dev link,
    input wire logic signed [IN_W-1:0] analog_in,
    output logic sample_taken
);
    logic sclk_s1_q;
    logic sclk_s2_q;
    logic sclk_s3_q;
    logic clk_rise;
    logic clk_fall;
    logic [CODE_W:0] pipe_q [STAGES];
    logic [CODE_W-1:0] code_q;
    logic flag_q;
    logic valid_q;
    logic taken_q;

    // {flag, code}; the flag is recomputed every sample
    function automatic logic [CODE_W:0] quantize(input logic signed [IN_W-1:0] v);
        logic signed [IN_W-1:0] off;
        off = v - IN_NEG_REF;
        if (v < IN_NEG_REF) begin
            quantize = {1'b1, CODE_ZERO};
        end else if (v >= IN_POS_REF) begin
            quantize = {1'b1, CODE_FULL};
        end else begin
            quantize = {1'b0, off[CODE_W-1:0]};
        end
    endfunction

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s1_q <= 1'b0;
            sclk_s2_q <= 1'b0;
            sclk_s3_q <= 1'b0;
        end else begin
            sclk_s1_q <= link.sample_clk;
            sclk_s2_q <= sclk_s1_q;
            sclk_s3_q <= sclk_s2_q;
        end
    end

    assign clk_rise = sclk_s2_q & ~sclk_s3_q;
    assign clk_fall = ~sclk_s2_q & sclk_s3_q;

    // Sample on rising edge, advance pipeline on falling edge
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < STAGES; i++) begin
                pipe_q[i] <= '0;
            end
        end else begin
            if (clk_rise) begin
                pipe_q[0] <= quantize(analog_in);
            end
            if (clk_fall) begin
                for (int i = 1; i < STAGES; i++) begin
                    pipe_q[i] <= pipe_q[i-1];
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            code_q <= CODE_ZERO;
            flag_q <= 1'b0;
            valid_q <= 1'b0;
            taken_q <= 1'b0;
        end else begin
            valid_q <= clk_rise;
            taken_q <= clk_rise;
            if (clk_rise) begin
                code_q <= pipe_q[STAGES-1][CODE_W-1:0];
                flag_q <= pipe_q[STAGES-1][CODE_W];
            end
        end
    end

    assign link.code = code_q;
    assign link.out_of_range_flag = flag_q;
    assign link.word_valid = valid_q;
    assign sample_taken = taken_q;
endmodule // aoc_converter

// ==== testbench/aoc_link_asserts.sv ====
`timescale 1ns/1ps
module aoc_link_asserts
    import aoc_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic sample_clk,
    input wire logic [CODE_W-1:0] code,
    input wire logic out_of_range_flag,
    input wire logic word_valid
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    property p_rail;
        word_valid && out_of_range_flag |-> code == 12'h000 || code == 12'hFFF;
    endproperty
    a_rail: assert property (p_rail) else $error("flag off rail");
    property p_mid;
        word_valid && code == 12'h800 |-> !out_of_range_flag;
    endproperty
    a_mid: assert property (p_mid) else $error("flag at midscale");
    property p_hold;
        $changed(code) || $changed(out_of_range_flag) |-> word_valid;
    endproperty
    a_hold: assert property (p_hold) else $error("pair moved alone");
    property p_pulse;
        word_valid |=> !word_valid;
    endproperty
    a_pulse: assert property (p_pulse) else $error("strobe too long");
    property p_half;
        sample_clk |=> !sample_clk;
    endproperty
    a_half: assert property (p_half) else $error("clock high twice");
    property p_answer;
        $rose(sample_clk) |-> ##[1:6] word_valid;
    endproperty
    a_answer: assert property (p_answer) else $error("no pair");
    property p_quiet;
        !sample_clk [*6] |=> !word_valid;
    endproperty
    a_quiet: assert property (p_quiet) else $error("pair w/o clock");
    property p_cause;
        word_valid |-> $past(sample_clk, 2) || $past(sample_clk, 3) || $past(sample_clk, 4);
    endproperty
    a_cause: assert property (p_cause) else $error("pair w/o edge");
    c_over: cover property (word_valid && out_of_range_flag && code == 12'hFFF);
    c_under: cover property (word_valid && out_of_range_flag && code == 12'h000);
    c_stop: cover property (!sample_clk [*8]);
endmodule // aoc_link_asserts

// ==== testbench/tb_adc_output_code_and_range_flag.sv ====
`timescale 1ns/1ps
module tb_adc_output_code_and_range_flag
    import aoc_pkg::*;
;
    logic mclk, arst_n, run, rdy, s_vld, flag, ovr, und, inr, taken;
    logic signed [IN_W-1:0] ain;
    logic [CODE_W-1:0] s_code, s_twos;
    logic [15:0] rs;
    logic [1:0] phase;
    logic [CODE_W:0] exp_q[$];
    logic [CODE_W:0] e;
    int err_total, n_checks, cyc;
    aoc_link_if link();
    aoc_converter i_aoc_converter(.mclk(mclk), .arst_n(arst_n), .link(link.dev),
        .analog_in(ain), .sample_taken(taken));
    aoc_capture i_aoc_capture(.mclk(mclk), .arst_n(arst_n), .link(link.cap), .run(run),
        .sample_valid(s_vld), .sample_ready(rdy), .sample_code(s_code), .sample_twos(s_twos),
        .out_of_range_flag(flag), .over_range(ovr), .under_range(und), .in_range(inr));
    aoc_link_asserts i_aoc_link_asserts(.mclk(mclk), .arst_n(arst_n),
        .sample_clk(link.sample_clk), .code(link.code),
        .out_of_range_flag(link.out_of_range_flag), .word_valid(link.word_valid));
    function automatic logic [15:0] xs(input logic [15:0] v);
        logic [15:0] t;
        t = v ^ (v << 7);
        t = t ^ (t >> 9);
        return t ^ (t << 8);
    endfunction
    function automatic logic [CODE_W:0] model(input logic signed [IN_W-1:0] x);
        if (x < IN_NEG_REF) return {1'b1, CODE_ZERO};
        if (x >= IN_POS_REF) return {1'b1, CODE_FULL};
        return {1'b0, 12'(x - IN_NEG_REF)};
    endfunction
    function automatic logic [IN_W-1:0] pick(input logic [15:0] r);
        case (r[2:0])
            3'h0: return 14'h37FF;
            3'h1: return 14'h3800;
            3'h2: return 14'h0000;
            3'h3: return 14'h07FF;
            3'h4: return 14'h0800;
            3'h5: return r[15:2];
            default: return {{3{r[13]}}, r[13:3]};
        endcase
    endfunction
    task automatic chk(input logic [CODE_W-1:0] got, input logic [CODE_W-1:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    always @(negedge mclk) begin
        rs = xs(rs);
        // Strobe follows the sampling edge: note the value just taken, then move on
        if (link.word_valid === 1'b1) begin
            exp_q.push_back(model(ain));
            ain = pick(rs);
        end
        rdy = (phase == 2'h0) ? rs[15] : (phase == 2'h2);
    end
    always @(posedge mclk) begin
        cyc++;
        if (arst_n === 1'b1) chk({11'h000, taken}, {11'h000, link.word_valid});
        if (s_vld === 1'b1 && rdy === 1'b1) begin
            e = exp_q.pop_front();
            chk(s_code, e[11:0]);
            chk(s_twos, e[11:0] ^ CODE_MID);
            chk({11'h000, flag}, {11'h000, e[12]});
            chk({9'h000, ovr, und, inr}, {9'h000, e[12] & e[11], e[12] & ~e[11], ~e[12]});
        end
        if (cyc == 3000) begin
            err_total++;
            tally_and_finish();
        end
    end
    initial begin
        arst_n = 1'b0;
        run = 1'b0;
        rdy = 1'b0;
        ain = '0;
        phase = 2'h0;
        rs = 16'h1ECB;
        // Pairs still in the pipeline at reset come out as zeros
        repeat (PIPE_STAGES - 1) exp_q.push_back(13'h0000);
        repeat (20) @(negedge mclk);
        arst_n = 1'b1;
        run = 1'b1;
        repeat (600) @(negedge mclk);
        phase = 2'h1;
        repeat (100) @(negedge mclk);
        chk({11'h000, exp_q.size() inside {[13:19]}}, 12'h001);
        phase = 2'h2;
        repeat (200) @(negedge mclk);
        run = 1'b0;
        repeat (100) @(negedge mclk);
        chk(12'(exp_q.size()), 12'(PIPE_STAGES - 1));
        tally_and_finish();
    end
endmodule // tb_adc_output_code_and_range_flag
